// file: hw/ddr_memory_port.sv
// How it works
// RULE_01 - Select fall starts, select rise ends transaction
// RULE_02 - Main clock may stop between transfers
// RULE_03 - Strobe edges during reads follow shifted clock
// RULE_04 - Host delays shifted clock, normally 90 degrees
// RULE_05 - Host parks shifted clock during writes
// RULE_06 - Host drives shifted complement low when single-ended
// RULE_07 - Differential mode uses both shifted clock pins
// RULE_08 - Single-ended mode ignores clock complement pin
// RULE_09 - Differential transfers referenced to clock crossings
// RULE_10 - Host drives strobe as write byte mask
// RULE_11 - Strobe driven at start, shows extra latency
// RULE_12 - Stacked variant always uses doubled latency
// RULE_13 - Hardware reset low returns device to idle
// RULE_14 - Hardware reset releases strobe and data lines
// RULE_15 - Unconnected hardware reset reads as high; code has no pull-up and only holds it high while the synchroniser is in reset
// RULE_16 - Command-address and data share eight-bit bus
// RULE_17 - Host starts with clock low, select high between
// RULE_18 - Shifted clock delay between 40 and 140 degrees
// RULE_19 - Reads carry one byte per clock edge
`timescale 1ns/10ps
`default_nettype none
`include "ddr_port_params.svh"

module ddr_memory_port #(
  parameter int LAT_CLOCKS = `DDR_LAT_CLOCKS_DEF,
  parameter int FIFO_DEPTH = `DDR_FIFO_DEPTH_DEF,
  parameter bit STACKED = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Bus pins from the host
  input wire logic select_n_i,
  input wire logic clock_i,
  input wire logic clock_complement_i,
  input wire logic shifted_strobe_clock_i,
  input wire logic shifted_strobe_clock_complement_i,
  input wire logic hw_reset_n_i,
  // Shared data bus
  input wire logic [`DDR_BYTE_W-1:0] dq_i,
  output logic [`DDR_BYTE_W-1:0] dq_o,
  output logic dq_oe_o,
  // Read-write data strobe
  input wire logic rw_data_strobe_i,
  output logic rw_data_strobe_o,
  output logic rw_data_strobe_oe_o,
  // Configuration
  input wire logic diff_clock_mode_i,
  input wire logic refresh_pending_i,
  // Command-address out
  output logic [`DDR_CA_W-1:0] command_address_o,
  output logic command_address_valid_o,
  // Write data out
  output logic [`DDR_BYTE_W-1:0] wr_data_o,
  output logic wr_mask_o,
  output logic wr_valid_o,
  // Read data in
  input wire logic [`DDR_BYTE_W-1:0] rd_data_i,
  input wire logic rd_valid_i,
  output logic rd_ready_o,
  // Status
  output ddr_port_pkg::port_state_t state_o
);

  import ddr_port_pkg::*;

  localparam logic [7:0] LAT_EDGES = 8'(LAT_CLOCKS * `DDR_EDGES_PER_CLK);
  localparam logic [7:0] LAT_EDGES_X = 8'(LAT_CLOCKS * `DDR_EDGES_PER_CLK * `DDR_EXTRA_MULT);

  // Reset release
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // Pin synchronisers
  logic [6:0] ctl_s;
  logic [`DDR_BYTE_W-1:0] dq_s;

  // Reset value keeps the hardware reset pin seen as high
  pin_sync #(.W(7), .RST_VAL(`DDR_CTL_RST)) u_ctl_sync ( // RULE_15
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i({rw_data_strobe_i, hw_reset_n_i, shifted_strobe_clock_complement_i,
          shifted_strobe_clock_i, clock_complement_i, clock_i, select_n_i}),
    .q_o(ctl_s)
  );

  pin_sync #(.W(`DDR_BYTE_W), .RST_VAL('0)) u_dq_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i(dq_i),
    .q_o(dq_s)
  );

  wire sel_s = ctl_s[0];
  wire ck_s = ctl_s[1];
  wire ckc_s = ctl_s[2];
  wire psc_s = ctl_s[3];
  wire pscc_s = ctl_s[4];
  wire hw_n_s = ctl_s[5];
  wire rw_data_strobe_s = ctl_s[6];

  // Clock levels and edges
  logic ck_lvl_r;
  logic psc_lvl_r;
  logic sel_prev_r;

  // Differential: level changes only at a crossing; single-ended: true pin alone
  wire ck_lvl = (diff_clock_mode_i && (ck_s == ckc_s)) ? ck_lvl_r : ck_s; // RULE_08 RULE_09
  wire psc_lvl = (diff_clock_mode_i && (psc_s == pscc_s)) ? psc_lvl_r : psc_s; // RULE_07
  // Edges come from sampled levels, so a stopped clock just gives none
  wire ck_edge = (ck_lvl != ck_lvl_r); // RULE_02
  wire psc_edge = (psc_lvl != psc_lvl_r);
  wire sel_fall = sel_prev_r && !sel_s; // RULE_01
  wire sel_rise = !sel_prev_r && sel_s; // RULE_01

  // Transaction state
  port_state_t state_r;
  port_state_t state_nxt;
  logic [2:0] ca_cnt_r;
  logic [7:0] lat_cnt_r;
  logic [`DDR_CA_W-1:0] ca_sh_r;
  logic ca_read_r;
  logic extra_r;

  wire start = (state_r == ST_IDLE) && sel_fall && hw_n_s;
  wire extra_nxt = start ? (STACKED || refresh_pending_i) : extra_r; // RULE_11 RULE_12
  wire [7:0] lat_last = (extra_r ? LAT_EDGES_X : LAT_EDGES) - 8'h01;
  wire ca_edge = (state_r == ST_CA) && ck_edge;
  wire ca_last = ca_edge && (ca_cnt_r == `DDR_CA_BYTES - 3'h1);
  wire lat_done = (state_r == ST_LAT) && ck_edge && (lat_cnt_r == lat_last);
  wire rd_take = (state_r == ST_READ) && ck_edge && !sel_rise && hw_n_s; // RULE_19
  wire wr_take = (state_r == ST_WRITE) && ck_edge && !sel_rise;
  wire [`DDR_BYTE_W-1:0] fifo_data;
  wire fifo_valid;
  wire [`DDR_BYTE_W-1:0] rd_byte = fifo_valid ? fifo_data : '0;
  wire drive_rw_data_strobe = (state_nxt == ST_CA) || (state_nxt == ST_READ) ||
                    ((state_nxt == ST_LAT) && ca_read_r);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start) begin
          state_nxt = ST_CA;
        end
      end
      ST_CA: begin
        if (ca_last) begin
          state_nxt = ST_LAT;
        end
      end
      ST_LAT: begin
        if (lat_done) begin
          state_nxt = ca_read_r ? ST_READ : ST_WRITE;
        end
      end
      ST_READ: state_nxt = ST_READ;
      ST_WRITE: state_nxt = ST_WRITE;
      default: state_nxt = ST_IDLE;
    endcase
    if (sel_rise || !hw_n_s) begin
      state_nxt = ST_IDLE; // RULE_01 RULE_13
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ck_lvl_r <= 1'b0;
      psc_lvl_r <= 1'b0;
      sel_prev_r <= 1'b1;
      state_r <= ST_IDLE;
      extra_r <= 1'b0;
    end else begin
      ck_lvl_r <= ck_lvl;
      psc_lvl_r <= psc_lvl;
      sel_prev_r <= sel_s;
      state_r <= state_nxt;
      extra_r <= extra_nxt;
    end
  end

  // Command-address capture from the shared bus
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ca_cnt_r <= '0;
      ca_sh_r <= '0;
      ca_read_r <= 1'b0;
      lat_cnt_r <= '0;
    end else begin
      if (start) begin
        ca_cnt_r <= '0;
      end else if (ca_edge) begin
        ca_cnt_r <= ca_cnt_r + 3'h1;
        ca_sh_r <= {ca_sh_r[`DDR_CA_W-`DDR_BYTE_W-1:0], dq_s}; // RULE_16
      end
      if (ca_edge && (ca_cnt_r == '0)) begin
        ca_read_r <= dq_s[`DDR_CA_RW_BIT];
      end
      if (state_r != ST_LAT) begin
        lat_cnt_r <= '0;
      end else if (ck_edge) begin
        lat_cnt_r <= lat_cnt_r + 8'h01;
      end
    end
  end

  // Pin drivers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dq_o <= '0;
      dq_oe_o <= 1'b0;
      rw_data_strobe_o <= 1'b0;
      rw_data_strobe_oe_o <= 1'b0;
    end else begin
      dq_oe_o <= (state_nxt == ST_READ); // RULE_14
      rw_data_strobe_oe_o <= drive_rw_data_strobe; // RULE_11 RULE_14
      if (rd_take) begin
        dq_o <= rd_byte; // RULE_19
      end
      if (state_nxt == ST_READ) begin
        rw_data_strobe_o <= psc_lvl; // RULE_03
      end else begin
        rw_data_strobe_o <= extra_nxt; // RULE_11
      end
    end
  end

  // User-side outputs; strobe sampled as write mask
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      command_address_o <= '0;
      command_address_valid_o <= 1'b0;
      wr_data_o <= '0;
      wr_mask_o <= 1'b0;
      wr_valid_o <= 1'b0;
      state_o <= ST_IDLE;
    end else begin
      command_address_valid_o <= ca_last && !sel_rise && hw_n_s;
      if (ca_last) begin
        command_address_o <= {ca_sh_r[`DDR_CA_W-`DDR_BYTE_W-1:0], dq_s};
      end
      wr_valid_o <= wr_take && hw_n_s;
      if (wr_take) begin
        wr_data_o <= dq_s;
        wr_mask_o <= rw_data_strobe_s; // RULE_10
      end
      state_o <= state_nxt;
    end
  end

  byte_fifo #(.WIDTH(`DDR_BYTE_W), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .in_data_i(rd_data_i),
    .in_valid_i(rd_valid_i),
    .in_ready_o(rd_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(rd_take)
  );

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  chk_select_start: assert property ( // RULE_01
    start |=> (state_r == ST_CA) ##1 (state_o == ST_CA || !hw_n_s || sel_s))
    else $error("select fall did not start a transaction");

  chk_select_end: assert property ( // RULE_01
    (sel_rise && state_r != ST_IDLE) |=> (state_r == ST_IDLE) && !dq_oe_o)
    else $error("select rise did not end the transaction");

  chk_strobe_shifted: assert property ( // RULE_03
    (state_nxt == ST_READ && state_r == ST_READ && psc_edge) |=>
      (rw_data_strobe_o == $past(psc_lvl)) && rw_data_strobe_oe_o)
    else $error("read strobe not following shifted clock");

  chk_single_psc: assert property ( // RULE_07
    !diff_clock_mode_i |-> (psc_lvl == psc_s))
    else $error("single-ended mode used shifted complement");

  chk_single_ck: assert property ( // RULE_08
    !diff_clock_mode_i && $changed(ckc_s) && ($stable(ck_s)) |-> !ck_edge)
    else $error("clock complement caused an edge in single-ended mode");

  chk_diff_crossing: assert property ( // RULE_09
    (diff_clock_mode_i && ck_s == ckc_s) |-> !ck_edge)
    else $error("edge seen without a clock crossing");

  chk_latency_flag: assert property ( // RULE_11
    start ##1 (state_r == ST_CA) |-> rw_data_strobe_oe_o && (rw_data_strobe_o == extra_r))
    else $error("strobe did not show latency at start");

  chk_stacked_double: assert property ( // RULE_12
    (state_r == ST_LAT && !extra_r) |-> !STACKED)
    else $error("stacked variant without doubled latency");

  chk_hw_reset_idle: assert property ( // RULE_13
    !hw_n_s |=> (state_r == ST_IDLE) ##1 (state_o == ST_IDLE || hw_n_s))
    else $error("hardware reset did not return to idle");

  chk_reset_release: assert property ( // RULE_14
    (!hw_n_s [*2]) |-> !dq_oe_o && !rw_data_strobe_oe_o)
    else $error("pins driven during hardware reset");

  chk_ca_capture: assert property ( // RULE_16
    ca_edge |=> (ca_sh_r[`DDR_BYTE_W-1:0] == $past(dq_s)))
    else $error("command-address byte not taken from the bus");

  chk_read_byte: assert property ( // RULE_19
    rd_take |=> (dq_o == $past(rd_byte)) && dq_oe_o)
    else $error("read byte not driven on clock edge");

  cov_read: cover property (lat_done && ca_read_r ##[1:200] rd_take);
  cov_write: cover property (lat_done && !ca_read_r ##[1:200] wr_take);
  cov_extra: cover property (start && extra_nxt ##[1:400] lat_done);
  cov_hw_reset: cover property ((state_r == ST_READ) ##1 !hw_n_s);

endmodule : ddr_memory_port

`default_nettype wire

// file: hw/ddr_port_params.svh
`ifndef DDR_PORT_PARAMS_SVH
`define DDR_PORT_PARAMS_SVH

// Bus widths
`define DDR_BYTE_W 8
`define DDR_CA_W 48
`define DDR_CA_BYTES 3'h6
`define DDR_CA_RW_BIT 7

// Defaults of the top-level parameters
`define DDR_LAT_CLOCKS_DEF 4
`define DDR_FIFO_DEPTH_DEF 8

// Edge counts per clock cycle, and latency multiplier with extra latency
`define DDR_EDGES_PER_CLK 2
`define DDR_EXTRA_MULT 2

// Reset values of the synchronised control pins {rw_data_strobe, hw_reset_n, pscc, psc, ckc, ck, sel_n}
`define DDR_CTL_RST 7'h21

`endif

// file: hw/ddr_port_pkg.sv
package ddr_port_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CA,
    ST_LAT,
    ST_READ,
    ST_WRITE
  } port_state_t;

endpackage : ddr_port_pkg

// file: hw/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser for a group of pins
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Pins and synchronised copy
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule : pin_sync

`default_nettype wire

// file: hw/byte_fifo.sv
`timescale 1ns/10ps
`default_nettype none

// Flip-flop FIFO with valid/ready on both sides
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Fill side
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // Drain side
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;

  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  assign out_valid_o = (count_r != '0);
  assign out_data_o = mem_r[rd_ptr_r];
  assign count_nxt = count_r + CW'(push) - CW'(pop);

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      in_ready_o <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == LAST_IDX) ? '0 : wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == LAST_IDX) ? '0 : rd_ptr_r + AW'(1);
      end
      count_r <= count_nxt;
      in_ready_o <= (count_nxt != FULL_CNT);
    end
  end

endmodule : byte_fifo

`default_nettype wire

// file: verif/host_model.sv
`timescale 1ns/10ps
`default_nettype none

// Host controller model: drives the bus pins, samples what the device returns
module host_model (
  // Clock and mode
  input wire logic clk_i,
  input wire logic diff_i,
  // Pins to the device
  output logic select_n_o,
  output logic clock_o,
  output logic clock_complement_o,
  output logic shifted_strobe_clock_o,
  output logic shifted_strobe_clock_complement_o,
  output logic hw_reset_n_o,
  output logic [7:0] dq_o,
  output logic dq_oe_o,
  output logic strobe_o,
  output logic strobe_oe_o,
  // Resolved bus wires
  input wire logic [7:0] dq_i,
  input wire logic strobe_i
);
  logic [7:0] rd_q[$];
  logic [1:0] rs_q[$];
  logic [1:0] start_flag;

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic idle();
    select_n_o = 1'b1;
    dq_oe_o = 1'b0;
    strobe_oe_o = 1'b0;
    hw_reset_n_o = 1'b1;
    clock_o = 1'b0;
    clock_complement_o = (diff_i === 1'b1);
    shifted_strobe_clock_o = 1'b0;
    shifted_strobe_clock_complement_o = (diff_i === 1'b1);
  endtask : idle

  // One transfer; the main clock toggles every 8 cycles, a stall stops it mid-data in both reads and writes
  task automatic xfer(input logic [47:0] ca, input int lat, input int nd, input bit abort);
    int last;
    last = 6 + lat + nd;
    clock_complement_o = diff_i;
    select_n_o = 1'b0;
    tick(5);
    start_flag[0] = strobe_i;
    tick(1);
    start_flag[1] = strobe_i;
    for (int e = 0; e < last; e++) begin
      if (abort && e == 6 + lat + 2) begin
        hw_reset_n_o = 1'b0;
        tick(12);
        return;
      end
      if (e == 6 + lat + 4) tick(24);
      dq_oe_o = !(ca[47] && e >= 6);
      dq_o = (e < 6) ? ca[47 - 8*e -: 8] : 8'h30 + 8'(e);
      strobe_oe_o = !ca[47] && e >= 6 + lat;
      strobe_o = e[0];
      tick(2);
      clock_o = ~clock_o;
      tick(1);
      // Complement lags by a cycle, so the crossing comes after the true pin moves
      if (diff_i) clock_complement_o = ~clock_o;
      tick(2);
      if (ca[47] && e >= 6 + lat) rs_q.push_back({strobe_i, shifted_strobe_clock_o});
      tick(1);
      if (ca[47]) shifted_strobe_clock_o = clock_o;
      // Unused complement moves alone in single-ended mode
      if (!diff_i) clock_complement_o = ~clock_complement_o;
      shifted_strobe_clock_complement_o = diff_i & ~shifted_strobe_clock_o;
      tick(2);
      if (ca[47] && e >= 6 + lat) rd_q.push_back(dq_i);
    end
    tick(4);
    idle();
    tick(8);
  endtask : xfer

  initial begin
    dq_o = 8'h00;
    strobe_o = 1'b0;
    idle();
  end
endmodule : host_model

`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import ddr_port_pkg::*;
  localparam int LAT = 2;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic diff = 1'b0;
  logic refresh = 1'b0;
  logic pat = 1'b0;
  logic sel_n, ck, ckc, shifted_strobe_clock, pscc, hwr_n, h_dq_oe, h_rw, h_rw_oe, dq_oe, rw, rw_oe;
  logic ca_v, wm, wv, rd_valid, rd_ready;
  logic [7:0] h_dq, dq_w, dq, wd, rd_data;
  logic rw_w;
  logic [47:0] ca, ca_seen;
  port_state_t state;
  logic [8:0] wr_q[$];
  int ca_cnt = 0;
  int cycles = 0;
  int err_count = 0;
  int tests_run = 0;

  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) pat <= ~pat;
  // Released lines show a pattern that changes every cycle
  assign dq_w = dq_oe ? dq : h_dq_oe ? h_dq : {8{pat}} ^ 8'h5A;
  assign rw_w = rw_oe ? rw : h_rw_oe ? h_rw : pat;

  ddr_memory_port #(.LAT_CLOCKS(LAT)) ddr_memory_port_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .select_n_i(sel_n), .clock_i(ck),
    .clock_complement_i(ckc), .shifted_strobe_clock_i(shifted_strobe_clock),
    .shifted_strobe_clock_complement_i(pscc), .hw_reset_n_i(hwr_n),
    .dq_i(dq_w), .dq_o(dq), .dq_oe_o(dq_oe), .rw_data_strobe_i(rw_w),
    .rw_data_strobe_o(rw), .rw_data_strobe_oe_o(rw_oe), .diff_clock_mode_i(diff),
    .refresh_pending_i(refresh), .command_address_o(ca), .command_address_valid_o(ca_v),
    .wr_data_o(wd), .wr_mask_o(wm), .wr_valid_o(wv), .rd_data_i(rd_data),
    .rd_valid_i(rd_valid), .rd_ready_o(rd_ready), .state_o(state));

  host_model host_model_inst (
    .clk_i(clk_i), .diff_i(diff), .select_n_o(sel_n), .clock_o(ck),
    .clock_complement_o(ckc), .shifted_strobe_clock_o(shifted_strobe_clock),
    .shifted_strobe_clock_complement_o(pscc), .hw_reset_n_o(hwr_n), .dq_o(h_dq),
    .dq_oe_o(h_dq_oe), .strobe_o(h_rw), .strobe_oe_o(h_rw_oe), .dq_i(dq_w), .strobe_i(rw_w));

  always @(posedge clk_i) begin
    if (ca_v === 1'b1) begin
      ca_seen <= ca;
      ca_cnt <= ca_cnt + 1;
    end
    if (wv === 1'b1) wr_q.push_back({wm, wd});
  end

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      close_out();
    end
  end

  task automatic close_out();
    $display("Checks run: %0d, errors: %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input bit ok, input string msg);
    tests_run++;
    if (!ok) begin
      err_count++;
      $display("ERROR %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic t_fill();
    int w;
    for (int i = 0; i < 8; i++) begin
      rd_data = 8'hA0 + 8'(i);
      rd_valid = 1'b1;
      w = 0;
      while (rd_ready !== 1'b1 && w < 50) begin
        tick(1);
        w++;
      end
      tick(1);
    end
    rd_valid = 1'b0;
    tick(2);
    chk(rd_ready === 1'b0, "full buffer still ready");
  endtask : t_fill

  task automatic t_read(input bit d, input bit x);
    int lat;
    int n;
    logic [47:0] c;
    lat = (x ? 4 : 2) * LAT;
    c = {8'hA5, 39'h1234_5678_9A, d};
    diff = d;
    refresh = x;
    t_fill();
    host_model_inst.rd_q.delete();
    host_model_inst.rs_q.delete();
    n = ca_cnt;
    host_model_inst.xfer(c, lat, 10, 1'b0);
    chk(ca_seen === c && ca_cnt == n + 1, "read command address");
    chk(host_model_inst.start_flag === {2{x}}, "read latency flag");
    chk(host_model_inst.rd_q.size() == 10, "read byte count");
    for (int i = 0; i < 10; i++) begin
      chk(host_model_inst.rd_q[i] === (i < 8 ? 8'hA0 + 8'(i) : 8'h00), "read byte");
      chk(host_model_inst.rs_q[i][1] === host_model_inst.rs_q[i][0], "read strobe");
    end
    chk(state === ST_IDLE && dq_oe === 1'b0 && rw_oe === 1'b0, "not ended");
    chk(rd_ready === 1'b1, "buffer not drained");
  endtask : t_read

  task automatic t_write(input bit d, input bit x);
    int lat;
    int e;
    logic [47:0] c;
    lat = (x ? 4 : 2) * LAT;
    c = {8'h25, 39'h7E_D2C3_B4A5, d};
    diff = d;
    refresh = x;
    wr_q.delete();
    tick(1);
    host_model_inst.xfer(c, lat, 6, 1'b0);
    chk(ca_seen === c, "write command address");
    chk(host_model_inst.start_flag === {2{x}}, "write latency flag");
    chk(wr_q.size() == 6, "write byte count");
    for (int i = 0; i < 6; i++) begin
      e = 6 + lat + i;
      chk(wr_q[i] === {e[0], 8'h30 + 8'(e)}, "write byte or mask");
    end
  endtask : t_write

  task automatic t_abort();
    diff = 1'b0;
    refresh = 1'b0;
    tick(1);
    host_model_inst.xfer({8'hA5, 40'h00_0000_0000}, 2 * LAT, 10, 1'b1);
    chk(dq_oe === 1'b0 && rw_oe === 1'b0, "bus held under reset");
    chk(state === ST_IDLE, "not idle under reset");
    host_model_inst.idle();
    tick(10);
  endtask : t_abort

  initial begin
    rd_data = 8'h00;
    rd_valid = 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    tick(10);
    chk(state === ST_IDLE && dq_oe === 1'b0 && rw_oe === 1'b0, "reset state");
    chk(rd_ready === 1'b1, "buffer not ready");
    t_read(1'b0, 1'b0);
    t_write(1'b0, 1'b1);
    t_read(1'b1, 1'b1);
    t_write(1'b1, 1'b0);
    t_abort();
    t_write(1'b0, 1'b0);
    close_out();
  end
endmodule : tb_top

`default_nettype wire
